/* File: design/paml_consts.vh */
`ifndef PAML_CONSTS_VH
`define PAML_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (configuration space byte addresses)
// ----------------------------------------------------------------
`define PAML_OFF_COR_STATUS 12'h110
`define PAML_OFF_COR_MASK 12'h114
`define PAML_OFF_CAP_CTRL 12'h118
`define PAML_OFF_HDR_DW0 12'h11C
`define PAML_OFF_HDR_DW1 12'h120
`define PAML_OFF_HDR_DW2 12'h124
`define PAML_OFF_HDR_DW3 12'h128

// ----------------------------------------------------------------
// Correctable mask and status layout
// ----------------------------------------------------------------
`define PAML_COR_IMPL 32'h000031C1
`define PAML_COR_STICKY 32'h000011C1
`define PAML_COR_MASK_RESET 32'h00002000
`define PAML_BIT_ADVISORY 13
`define PAML_BIT_REPLAY_EXP 12
`define PAML_BIT_REPLAY_ROLL 8
`define PAML_BIT_LINK_FAULT 7
`define PAML_BIT_TLP_FAULT 6
`define PAML_BIT_RX_ERR 0

// ----------------------------------------------------------------
// Capabilities and control layout
// ----------------------------------------------------------------
`define PAML_CAP_RESET 32'h000000A0
`define PAML_BIT_CHK_EN 8
`define PAML_BIT_CHK_CAP 7
`define PAML_BIT_GEN_EN 6
`define PAML_BIT_GEN_CAP 5
`define PAML_PTR_W 5
`define PAML_UNC_ECRC_VEC 32'h00080000

// ----------------------------------------------------------------
// Header log
// ----------------------------------------------------------------
`define PAML_HDR_DWORDS 4
`define PAML_HDR_RESET 32'h00000000

`endif

/* File: design/paml_cor_status.v */
`timescale 1ns/10ps
`default_nettype none
`include "paml_consts.vh"

module paml_cor_status #(
  parameter [31:0] IMPL = `PAML_COR_IMPL,
  parameter [31:0] STICKY = `PAML_COR_STICKY
) (
  input wire clk,
  input wire rst_fund,
  input wire rst_hot,
  input wire [31:0] set_vec,
  input wire [31:0] clr_vec,
  output wire [31:0] status
);

  // ----------------------------------------------------------------
  // One flag per bit; unimplemented bits stay zero
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1)
    begin : g_bit
      if (IMPL[i])
      begin : g_impl
        reg flag_r;
        wire bit_rst;
        assign bit_rst = STICKY[i] ? rst_fund : rst_hot;
        always @(posedge clk or posedge bit_rst)
        begin
          if (bit_rst)
            flag_r <= 1'b0;
          else if (set_vec[i])
            flag_r <= 1'b1;
          else if (clr_vec[i])
            flag_r <= 1'b0;
        end
        assign status[i] = flag_r;
      end
      else
      begin : g_rsvd
        assign status[i] = 1'b0;
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: design/paml_hdr_log.v */
`timescale 1ns/10ps
`default_nettype none
`include "paml_consts.vh"

module paml_hdr_log #(
  parameter DWORDS = `PAML_HDR_DWORDS
) (
  input wire clk,
  input wire rst_fund,
  input wire capture,
  input wire hdr_4dw,
  input wire [32*DWORDS-1:0] hdr_wire,
  output wire [32*DWORDS-1:0] hdr_log
);

  // ----------------------------------------------------------------
  // Wire order puts the first byte high; the log wants it low
  // ----------------------------------------------------------------
  function [31:0] paml_swap;
    input [31:0] dw;
    begin
      paml_swap = {dw[7:0], dw[15:8], dw[23:16], dw[31:24]};
    end
  endfunction

  genvar d;
  generate
    for (d = 0; d < DWORDS; d = d + 1)
    begin : g_dw
      reg [31:0] log_r;
      wire [31:0] in_dw;
      wire used;
      assign in_dw = hdr_wire[32*(DWORDS-d)-1 -: 32];
      assign used = (d < DWORDS - 1) | hdr_4dw;
      always @(posedge clk or posedge rst_fund)
      begin
        if (rst_fund)
          log_r <= `PAML_HDR_RESET;
        else if (capture)
          log_r <= used ? paml_swap(in_dw) : `PAML_HDR_RESET;
      end
      assign hdr_log[32*d+31 -: 32] = log_r;
    end
  endgenerate

endmodule

`default_nettype wire

/* File: design/paml_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "paml_consts.vh"

module paml_top #(
  parameter ADDR_W = 12,
  parameter DWORDS = `PAML_HDR_DWORDS
) (
  input wire clk,
  input wire sys_rst,
  input wire platform_reset_n,
  input wire global_reset_n,
  input wire cfg_rd,
  input wire cfg_wr,
  input wire [ADDR_W-1:0] cfg_addr,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  output reg [31:0] cfg_rdata,
  output reg cfg_rdone,
  input wire [31:0] cor_err_pulse,
  input wire [31:0] unc_err_pulse,
  input wire ecrc_mismatch_pulse,
  input wire [32*DWORDS-1:0] err_hdr,
  input wire err_hdr_4dw,
  input wire unc_first_release,
  output reg cor_msg_req,
  output reg ecrc_err_report,
  output reg hdr_logged,
  output wire e2e_crc_check_enable,
  output wire e2e_crc_generate_enable,
  output wire [`PAML_PTR_W-1:0] first_err_ptr,
  output wire [31:0] cor_status
);

  // ----------------------------------------------------------------
  // Reset generation
  // ----------------------------------------------------------------
  // Pins assert asynchronously; release is synchronised so sticky
  // flops never leave reset on a metastable edge.
  wire fundamental_reset_n;
  wire fund_raw;
  reg [1:0] fund_sync_r;
  wire rst_fund;
  wire rst_hot;

  assign fundamental_reset_n = platform_reset_n & global_reset_n;
  assign fund_raw = ~fundamental_reset_n;

  always @(posedge clk or posedge fund_raw)
  begin
    if (fund_raw)
      fund_sync_r <= 2'h0;
    else
      fund_sync_r <= {fund_sync_r[0], 1'b1};
  end

  assign rst_fund = ~fund_sync_r[1];
  assign rst_hot = sys_rst | rst_fund;

  // ----------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------
  localparam [31:0] MASK_RST = `PAML_COR_MASK_RESET;
  localparam [31:0] STICKY_RST = `PAML_COR_MASK_RESET & `PAML_COR_STICKY;
  localparam [31:0] CAP_FLAGS = `PAML_CAP_RESET;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  // Only address bits above the byte offset select a register
  function paml_hit;
    input [ADDR_W-1:0] addr;
    input [11:0] off;
    begin
      paml_hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    end
  endfunction

  function [31:0] paml_lanes;
    input [3:0] be;
    begin
      paml_lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Lowest set bit wins when several classes arrive together
  function [`PAML_PTR_W-1:0] paml_first;
    input [31:0] vec;
    integer k;
    begin
      paml_first = {`PAML_PTR_W{1'b0}};
      for (k = 31; k >= 0; k = k - 1)
      begin
        if (vec[k])
          paml_first = k[`PAML_PTR_W-1:0];
      end
    end
  endfunction

  wire wr_status;
  wire wr_mask;
  wire wr_ctrl;
  wire [31:0] lane_mask;
  wire [31:0] wr_bits;

  assign wr_status = cfg_wr & paml_hit(cfg_addr, `PAML_OFF_COR_STATUS);
  assign wr_mask = cfg_wr & paml_hit(cfg_addr, `PAML_OFF_COR_MASK);
  assign wr_ctrl = cfg_wr & paml_hit(cfg_addr, `PAML_OFF_CAP_CTRL);
  assign lane_mask = paml_lanes(cfg_be);
  assign wr_bits = cfg_wdata & lane_mask;

  // ----------------------------------------------------------------
  // Correctable error mask
  // ----------------------------------------------------------------
  reg adv_mask_r;
  reg [31:0] sticky_mask_r;
  reg [31:0] sticky_mask_nxt;
  reg [31:0] cor_mask;

  // Advisory mask is not sticky, so any reset brings it back to one
  always @(posedge clk or posedge rst_hot)
  begin
    if (rst_hot)
      adv_mask_r <= MASK_RST[`PAML_BIT_ADVISORY];
    else if (wr_mask & cfg_be[1])
      adv_mask_r <= cfg_wdata[`PAML_BIT_ADVISORY];
  end

  always @*
  begin
    sticky_mask_nxt = sticky_mask_r;
    if (wr_mask)
      sticky_mask_nxt = ((sticky_mask_r & ~lane_mask) | wr_bits)
                        & `PAML_COR_STICKY;
  end

  always @(posedge clk or posedge rst_fund)
  begin
    if (rst_fund)
      sticky_mask_r <= STICKY_RST;
    else
      sticky_mask_r <= sticky_mask_nxt;
  end

  // Sticky and hot-reset bits share one readable word
  always @*
  begin
    cor_mask = sticky_mask_r;
    cor_mask[`PAML_BIT_ADVISORY] = adv_mask_r;
  end

  // ----------------------------------------------------------------
  // Correctable error events and status
  // ----------------------------------------------------------------
  wire [31:0] cor_hit;
  wire [31:0] status_clr;

  assign cor_hit = cor_err_pulse & ~cor_mask & `PAML_COR_IMPL;
  assign status_clr = wr_status ? wr_bits : 32'h00000000;

  paml_cor_status #(
    .IMPL(`PAML_COR_IMPL),
    .STICKY(`PAML_COR_STICKY)
  ) u_status (
    .clk(clk),
    .rst_fund(rst_fund),
    .rst_hot(rst_hot),
    .set_vec(cor_hit),
    .clr_vec(status_clr),
    .status(cor_status)
  );

  // ----------------------------------------------------------------
  // Capabilities and control
  // ----------------------------------------------------------------
  reg chk_en_r;
  reg gen_en_r;

  // Only the two enables are writable; flags and pointer are not
  always @(posedge clk or posedge rst_fund)
  begin
    if (rst_fund)
    begin
      chk_en_r <= 1'b0;
      gen_en_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      if (cfg_be[1])
        chk_en_r <= cfg_wdata[`PAML_BIT_CHK_EN];
      if (cfg_be[0])
        gen_en_r <= cfg_wdata[`PAML_BIT_GEN_EN];
    end
  end

  assign e2e_crc_check_enable = chk_en_r;
  assign e2e_crc_generate_enable = gen_en_r;

  // ----------------------------------------------------------------
  // Uncorrectable events and first error pointer
  // ----------------------------------------------------------------
  wire ecrc_hit;
  wire [31:0] unc_eff;
  wire unc_any;
  reg [`PAML_PTR_W-1:0] first_err_r;
  reg first_held_r;

  // Mismatches are dropped at the source while checking is off
  assign ecrc_hit = ecrc_mismatch_pulse & chk_en_r;
  assign unc_eff = unc_err_pulse
                   | (ecrc_hit ? `PAML_UNC_ECRC_VEC : 32'h00000000);
  assign unc_any = |unc_eff;

  // A new error in the release cycle is kept: capture beats release
  always @(posedge clk or posedge rst_fund)
  begin
    if (rst_fund)
    begin
      first_err_r <= {`PAML_PTR_W{1'b0}};
      first_held_r <= 1'b0;
    end
    else if (unc_any & (~first_held_r | unc_first_release))
    begin
      first_err_r <= paml_first(unc_eff);
      first_held_r <= 1'b1;
    end
    else if (unc_first_release)
      first_held_r <= 1'b0;
  end

  assign first_err_ptr = first_err_r;

  // ----------------------------------------------------------------
  // Header log
  // ----------------------------------------------------------------
  wire log_capture;
  wire [32*DWORDS-1:0] hdr_log;

  // Later errors overwrite the log; no history is kept
  assign log_capture = (|cor_hit) | unc_any;

  paml_hdr_log #(
    .DWORDS(DWORDS)
  ) u_log (
    .clk(clk),
    .rst_fund(rst_fund),
    .capture(log_capture),
    .hdr_4dw(err_hdr_4dw),
    .hdr_wire(err_hdr),
    .hdr_log(hdr_log)
  );

  // ----------------------------------------------------------------
  // Event outputs
  // ----------------------------------------------------------------
  // Single-cycle pulses; the consumer must latch them itself
  always @(posedge clk or posedge rst_hot)
  begin
    if (rst_hot)
    begin
      cor_msg_req <= 1'b0;
      ecrc_err_report <= 1'b0;
      hdr_logged <= 1'b0;
    end
    else
    begin
      cor_msg_req <= |cor_hit;
      ecrc_err_report <= ecrc_hit;
      hdr_logged <= log_capture;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Capability flags are constants, so reads ignore byte enables
  // Unmapped offsets read zero rather than raising an error
  reg [31:0] rd_nxt;
  reg [31:0] ctrl_word;

  always @*
  begin
    ctrl_word = CAP_FLAGS;
    ctrl_word[`PAML_BIT_CHK_EN] = chk_en_r;
    ctrl_word[`PAML_BIT_GEN_EN] = gen_en_r;
    ctrl_word[`PAML_PTR_W-1:0] = first_err_r;
  end

  always @*
  begin
    rd_nxt = 32'h00000000;
    if (paml_hit(cfg_addr, `PAML_OFF_COR_STATUS))
      rd_nxt = cor_status;
    else if (paml_hit(cfg_addr, `PAML_OFF_COR_MASK))
      rd_nxt = cor_mask & `PAML_COR_IMPL;
    else if (paml_hit(cfg_addr, `PAML_OFF_CAP_CTRL))
      rd_nxt = ctrl_word;
    else if (paml_hit(cfg_addr, `PAML_OFF_HDR_DW0))
      rd_nxt = hdr_log[31:0];
    else if (paml_hit(cfg_addr, `PAML_OFF_HDR_DW1))
      rd_nxt = hdr_log[63:32];
    else if (paml_hit(cfg_addr, `PAML_OFF_HDR_DW2))
      rd_nxt = hdr_log[95:64];
    else if (paml_hit(cfg_addr, `PAML_OFF_HDR_DW3))
      rd_nxt = hdr_log[127:96];
  end

  always @(posedge clk or posedge rst_hot)
  begin
    if (rst_hot)
    begin
      cfg_rdata <= 32'h00000000;
      cfg_rdone <= 1'b0;
    end
    else
    begin
      cfg_rdone <= cfg_rd;
      if (cfg_rd)
        cfg_rdata <= rd_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: test/paml_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module paml_asserts #(
  parameter ADDR_W = 12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic platform_reset_n,
  input wire logic global_reset_n,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [ADDR_W-1:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic [31:0] cor_err_pulse,
  input wire logic [31:0] unc_err_pulse,
  input wire logic ecrc_mismatch_pulse,
  input wire logic cor_msg_req,
  input wire logic ecrc_err_report,
  input wire logic hdr_logged,
  input wire logic e2e_crc_check_enable,
  input wire logic e2e_crc_generate_enable,
  input wire logic [4:0] first_err_ptr,
  input wire logic [31:0] cor_status
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Hot reset keeps sticky state, but outputs may drop then
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !platform_reset_n || !global_reset_n);
  wire logic rd_msk = cfg_rd && cfg_addr[11:2] == 10'h045;
  wire logic rd_ctl = cfg_rd && cfg_addr[11:2] == 10'h046;
  wire logic wr_sts = cfg_wr && cfg_addr[11:2] == 10'h044;
  a_mask_rsvd_zero: assert property (
    rd_msk |=> (cfg_rdata & 32'hFFFFCE3E) == 32'h00000000)
    else $error("mask reserved bits read nonzero");
  a_cap_bits_one: assert property (
    rd_ctl |=> cfg_rdata[7] && cfg_rdata[5] && cfg_rdata[31:9] == 23'h0)
    else $error("capability bits wrong");
  a_chk_en_read: assert property (
    rd_ctl |=> cfg_rdata[8] == $past(e2e_crc_check_enable))
    else $error("check enable read mismatch");
  a_gen_en_read: assert property (
    rd_ctl |=> cfg_rdata[6] == $past(e2e_crc_generate_enable))
    else $error("generate enable read mismatch");
  a_ptr_read: assert property (
    rd_ctl |=> cfg_rdata[4:0] == $past(first_err_ptr))
    else $error("pointer read mismatch");
  a_ptr_cause: assert property (
    $changed(first_err_ptr) |->
      $past(unc_err_pulse != 32'h0 || ecrc_mismatch_pulse))
    else $error("pointer moved without error");
  a_crc_report: assert property (
    1'h1 |=> ecrc_err_report ==
      $past(ecrc_mismatch_pulse && e2e_crc_check_enable))
    else $error("crc report wrong");
  a_log_cause: assert property (
    hdr_logged |-> $past(cor_err_pulse != 32'h0 ||
      unc_err_pulse != 32'h0 || ecrc_mismatch_pulse))
    else $error("log without error");
  a_unc_logs: assert property (
    unc_err_pulse != 32'h0 |=> hdr_logged)
    else $error("uncorrectable not logged");
  a_msg_cause: assert property (
    cor_msg_req |-> $past(cor_err_pulse != 32'h0))
    else $error("message without error");
  a_status_cause: assert property (
    (cor_status & ~$past(cor_status) & ~$past(cor_err_pulse)) == 32'h0)
    else $error("status set without error");
  a_status_sticky: assert property (
    (~cor_status & $past(cor_status)) != 32'h0 |-> $past(wr_sts))
    else $error("status cleared without write");
  c_msg: cover property (cor_msg_req);
  c_report: cover property (ecrc_err_report);
  c_ptr: cover property ($changed(first_err_ptr));
endmodule
bind paml_top paml_asserts #(.ADDR_W(ADDR_W)) paml_asserts_inst (
  .clk(clk), .sys_rst(sys_rst), .platform_reset_n(platform_reset_n),
  .global_reset_n(global_reset_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
  .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
  .cor_err_pulse(cor_err_pulse), .unc_err_pulse(unc_err_pulse),
  .ecrc_mismatch_pulse(ecrc_mismatch_pulse), .cor_msg_req(cor_msg_req),
  .ecrc_err_report(ecrc_err_report), .hdr_logged(hdr_logged),
  .e2e_crc_check_enable(e2e_crc_check_enable),
  .e2e_crc_generate_enable(e2e_crc_generate_enable),
  .first_err_ptr(first_err_ptr), .cor_status(cor_status));
`default_nettype wire

/* File: test/test_pcie_aer_mask_control_log.sv */
`timescale 1ns/10ps
`default_nettype none
module test_pcie_aer_mask_control_log;
  logic clk, sys_rst, platform_reset_n, global_reset_n, cfg_rd, cfg_wr;
  logic ecrc_mismatch_pulse, err_hdr_4dw, unc_first_release, cfg_rdone;
  logic cor_msg_req, ecrc_err_report, hdr_logged;
  logic e2e_crc_check_enable, e2e_crc_generate_enable;
  logic [11:0] cfg_addr, a;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, cor_err_pulse, unc_err_pulse;
  logic [31:0] cor_status, b;
  logic [127:0] err_hdr, h;
  logic [4:0] first_err_ptr;
  logic [31:0] exp_q[$];
  int bits[6] = '{13, 12, 8, 7, 6, 0};
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  paml_top paml_top_inst (.clk(clk), .sys_rst(sys_rst),
    .platform_reset_n(platform_reset_n), .global_reset_n(global_reset_n),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rdone(cfg_rdone),
    .cor_err_pulse(cor_err_pulse), .unc_err_pulse(unc_err_pulse),
    .ecrc_mismatch_pulse(ecrc_mismatch_pulse), .err_hdr(err_hdr),
    .err_hdr_4dw(err_hdr_4dw), .unc_first_release(unc_first_release),
    .cor_msg_req(cor_msg_req), .ecrc_err_report(ecrc_err_report),
    .hdr_logged(hdr_logged), .e2e_crc_check_enable(e2e_crc_check_enable),
    .e2e_crc_generate_enable(e2e_crc_generate_enable),
    .first_err_ptr(first_err_ptr), .cor_status(cor_status));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [31:0] sw(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(negedge clk);
    cfg_wr = 1'h1;
    cfg_addr = ad;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'h0;
  endtask
  // Expected read data queued; the watcher below compares it
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    @(negedge clk);
    cfg_rd = 1'h1;
    cfg_addr = ad;
    exp_q.push_back(e);
    @(negedge clk);
    cfg_rd = 1'h0;
  endtask
  task automatic ev(input logic [31:0] c, input logic [31:0] u,
    input logic m, input logic msg, input logic lg);
    @(negedge clk);
    cor_err_pulse = c;
    unc_err_pulse = u;
    ecrc_mismatch_pulse = m;
    err_hdr = {$urandom, $urandom, $urandom, $urandom};
    @(negedge clk);
    cor_err_pulse = 32'h0;
    unc_err_pulse = 32'h0;
    ecrc_mismatch_pulse = 1'h0;
    check({31'h0, cor_msg_req}, {31'h0, msg});
    check({31'h0, hdr_logged}, {31'h0, lg});
  endtask
  task automatic fund(input logic pin);
    @(negedge clk);
    platform_reset_n = pin;
    global_reset_n = ~pin;
    repeat (2) @(negedge clk);
    platform_reset_n = 1'h1;
    global_reset_n = 1'h1;
    repeat (3) @(negedge clk);
  endtask
  always @(negedge clk)
    if (cfg_rdone === 1'h1)
      check(cfg_rdata, exp_q.pop_front());
  // Ceiling well above the roughly 190 cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_mismatch++;
      complete_run;
    end
  end
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    {cfg_rd, cfg_wr, ecrc_mismatch_pulse, err_hdr_4dw} = 4'h0;
    {unc_first_release, platform_reset_n, global_reset_n} = 3'h0;
    sys_rst = 1'h1;
    cfg_addr = 12'h000;
    cfg_be = 4'hF;
    cfg_wdata = 32'h0;
    cor_err_pulse = 32'h0;
    unc_err_pulse = 32'h0;
    err_hdr = 128'h0;
    void'($urandom(61101));
    repeat (2) @(negedge clk);
    {sys_rst, platform_reset_n, global_reset_n} = 3'h3;
    repeat (3) @(negedge clk);
    rd(12'h114, 32'h00002000);
    rd(12'h118, 32'h000000A0);
    wr(12'h11C, 32'hFFFFFFFF);
    for (a = 12'h11C; a < 12'h12C; a += 12'h004)
      rd(a, 32'h0);
    rd(12'h200, 32'h0);
    cfg_be = 4'h1;
    wr(12'h114, 32'hFFFFFFFF);
    cfg_be = 4'hF;
    rd(12'h114, 32'h000020C1);
    wr(12'h114, 32'hFFFFFFFF);
    rd(12'h114, 32'h000031C1);
    wr(12'h118, 32'hFFFFFFFF);
    rd(12'h118, 32'h000001E0);
    check({30'h0, e2e_crc_check_enable, e2e_crc_generate_enable}, 32'h3);
    wr(12'h118, 32'h0);
    foreach (bits[k])
    begin
      b = 32'h1 << bits[k];
      wr(12'h114, 32'h000031C1 ^ b);
      ev(b, 32'h0, 1'h0, 1'h1, 1'h1);
      check(cor_status, b);
      h = err_hdr;
      wr(12'h110, ~b);
      check(cor_status, b);
      wr(12'h110, b);
      check(cor_status, 32'h0);
      wr(12'h114, 32'h000031C1);
      ev(b, 32'h0, 1'h0, 1'h0, 1'h0);
      check(cor_status, 32'h0);
      rd(12'h11C, sw(h[127:96]));
      rd(12'h128, 32'h0);
    end
    ev(32'h0, 32'h0, 1'h1, 1'h0, 1'h0);
    check({31'h0, ecrc_err_report}, 32'h0);
    wr(12'h118, 32'h00000100);
    ev(32'h0, 32'h0, 1'h1, 1'h0, 1'h1);
    check({31'h0, ecrc_err_report}, 32'h1);
    rd(12'h118, 32'h000001B3);
    ev(32'h0, 32'h10, 1'h0, 1'h0, 1'h1);
    check({27'h0, first_err_ptr}, 32'h13);
    @(negedge clk);
    unc_first_release = 1'h1;
    @(negedge clk);
    unc_first_release = 1'h0;
    err_hdr_4dw = 1'h1;
    ev(32'h0, 32'h5000, 1'h0, 1'h0, 1'h1);
    check({27'h0, first_err_ptr}, 32'hC);
    h = err_hdr;
    rd(12'h120, sw(h[95:64]));
    rd(12'h128, sw(h[31:0]));
    wr(12'h114, 32'h000011C1);
    @(negedge clk);
    sys_rst = 1'h1;
    @(negedge clk);
    sys_rst = 1'h0;
    rd(12'h114, 32'h000031C1);
    rd(12'h118, 32'h000001AC);
    rd(12'h128, sw(h[31:0]));
    for (int p = 0; p < 2; p++)
    begin
      wr(12'h114, 32'h000011C1);
      fund(p[0]);
      rd(12'h114, 32'h00002000);
      rd(12'h118, 32'h000000A0);
      rd(12'h128, 32'h0);
    end
    repeat (2) @(negedge clk);
    check(exp_q.size(), 32'h0);
    complete_run;
  end
endmodule
`default_nettype wire
